// File: pkg/rail_regs_pkg.sv
// Constants and field layout of the rail control register bank
// Summary of operation
// - Rail six on bit resets one; zero forces off
// - Rail six sleep arm nonzero enables pin switching
// - Rail six bits 3-2 kept at 3h
// - Rail six bit 1 selects auto or PWM
// - LDO two sleep arm resets zero, nonzero arms
// - LDO two bits 3-1 reset and kept 6h
// - LDO two on bit resets zero; zero forces off
// - LDO three sleep arm resets 3h, enabled
// - LDO three bits 3-1 reset and kept 6h
// - LDO three on bit resets zero; forces off
// - Enabling rail clears its discharge field
// - Four discharge fields, each resets to 100 ohm
// - Sleep entry copies sleep code into active code
package rail_regs_pkg;
  localparam int          DATA_W          = 8;
  localparam int          ADDR_W          = 8;
  localparam int          CODE_W          = 7;
  localparam logic [7:0]  BUCK_SIX_ADDR   = 8'h27;
  localparam logic [7:0]  LDO_TWO_ADDR    = 8'h28;
  localparam logic [7:0]  LDO_THREE_ADDR  = 8'h29;
  localparam logic [7:0]  DISCH_ONE_ADDR  = 8'h40;
  localparam logic [7:0]  BUCK_SIX_RST    = 8'h0d;
  localparam logic [7:0]  LDO_TWO_RST     = 8'h0c;
  localparam logic [7:0]  LDO_THREE_RST   = 8'h3c;
  localparam logic [7:0]  DISCH_ONE_RST   = 8'h55;
  localparam logic [7:0]  CTRL_WR_MASK    = 8'h3f;
  localparam int          ON_BIT          = 0;
  localparam int          MODE_BIT        = 1;
  localparam int          ARM_LSB         = 4;
  localparam int          BUCK_TRIM_LSB   = 2;
  localparam int          LDO_TRIM_LSB    = 1;
  localparam logic [1:0]  BUCK_TRIM_OK    = 2'h3;
  localparam logic [2:0]  LDO_TRIM_OK     = 3'h6;
  localparam logic [1:0]  DISCH_NONE      = 2'h0;
  localparam logic [1:0]  ARM_OFF         = 2'h0;
  localparam logic [CODE_W-1:0] CODE_RST  = 7'h00;
endpackage

// File: verilog/rail_sleep_track.sv
`timescale 1ns/1ps
// One rail's active voltage code with sleep-entry copy
module rail_sleep_track
  import rail_regs_pkg::*;
(
  input  wire logic              sys_clk,
  input  wire logic              sys_rst,
  input  wire logic              clk_en,
  input  wire logic              sleep_armed,
  input  wire logic              sleep_level,
  input  wire logic [CODE_W-1:0] normal_code,
  input  wire logic [CODE_W-1:0] sleep_code,
  output logic      [CODE_W-1:0] active_code
);
  logic sleep_reg;
  wire  sleep_entry = sleep_armed & sleep_level & ~sleep_reg;

  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      sleep_reg   <= 1'b0;
      active_code <= CODE_RST;
    end else if (clk_en) begin
      sleep_reg <= sleep_armed & sleep_level;
      if (sleep_entry)
        active_code <= sleep_code;
      else if (!(sleep_armed & sleep_level))
        active_code <= normal_code;
    end
  end
endmodule

// File: verilog/rail_control_regs.sv
`timescale 1ns/1ps
// Rail control register bank: three control registers and one discharge register
module rail_control_regs
  import rail_regs_pkg::*;
(
  input  wire logic              sys_clk,
  input  wire logic              sys_rst,
  input  wire logic              clk_en,
  input  wire logic              wr_en,
  input  wire logic [ADDR_W-1:0] addr,
  input  wire logic [DATA_W-1:0] wr_data,
  output logic      [DATA_W-1:0] rd_data,
  input  wire logic              sleep_pin_one,
  input  wire logic              sleep_pin_two,
  input  wire logic              sleep_pin_sel,
  input  wire logic [3:0]        rail_enable_evt,
  input  wire logic [CODE_W-1:0] rail6_voltage_code,
  input  wire logic [CODE_W-1:0] rail6_sleep_voltage_code,
  input  wire logic [CODE_W-1:0] ldo_two_voltage_code,
  input  wire logic [CODE_W-1:0] ldo_two_sleep_voltage_code,
  input  wire logic [CODE_W-1:0] ldo_three_voltage_code,
  input  wire logic [CODE_W-1:0] ldo_three_sleep_voltage_code,
  output logic                   rail6_on,
  output logic                   rail6_op_mode,
  output logic                   rail6_vid_valid,
  output logic                   ldo_two_on,
  output logic                   ldo_two_vid_valid,
  output logic                   ldo_three_on,
  output logic                   ldo_three_vid_valid,
  output logic      [CODE_W-1:0] rail6_active_code,
  output logic      [CODE_W-1:0] ldo_two_active_code,
  output logic      [CODE_W-1:0] ldo_three_active_code,
  output logic      [1:0]        rail1_discharge_sel,
  output logic      [1:0]        rail2_discharge_sel,
  output logic      [1:0]        rail3_discharge_sel,
  output logic      [1:0]        rail4_discharge_sel
);
  logic [DATA_W-1:0] buck_six_reg, ldo_two_reg, ldo_three_reg, disch_reg;
  logic [DATA_W-1:0] disch_next;

  wire hit_six   = wr_en & (addr == BUCK_SIX_ADDR);
  wire hit_two   = wr_en & (addr == LDO_TWO_ADDR);
  wire hit_three = wr_en & (addr == LDO_THREE_ADDR);
  wire hit_disch = wr_en & (addr == DISCH_ONE_ADDR);
  // Factory choice of sleep pin is a strap-like select input
  wire sleep_level = sleep_pin_sel ? sleep_pin_two : sleep_pin_one;

  wire [DATA_W-1:0] disch_wr = hit_disch ? wr_data : disch_reg;
  // Enable wins over a same-cycle write, so the enabled rail's discharge field clears on a clk_en cycle
  always_comb begin
    disch_next = disch_wr;
    for (int i = 0; i < 4; i++)
      if (rail_enable_evt[i])
        disch_next[2*i +: 2] = DISCH_NONE;
  end

  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      buck_six_reg  <= BUCK_SIX_RST;
      ldo_two_reg   <= LDO_TWO_RST;
      ldo_three_reg <= LDO_THREE_RST;
      disch_reg     <= DISCH_ONE_RST;
    end else if (clk_en) begin
      if (hit_six)
        buck_six_reg <= wr_data & CTRL_WR_MASK;
      if (hit_two)
        ldo_two_reg <= wr_data & CTRL_WR_MASK;
      if (hit_three)
        ldo_three_reg <= wr_data & CTRL_WR_MASK;
      disch_reg <= disch_next;
    end
  end

  assign rd_data = (addr == BUCK_SIX_ADDR)  ? buck_six_reg  :
                   (addr == LDO_TWO_ADDR)   ? ldo_two_reg   :
                   (addr == LDO_THREE_ADDR) ? ldo_three_reg :
                   (addr == DISCH_ONE_ADDR) ? disch_reg     : 8'h00;

  // Register bit gates the rail off regardless of control pins
  assign rail6_on      = buck_six_reg[ON_BIT];
  assign ldo_two_on    = ldo_two_reg[ON_BIT];
  assign ldo_three_on  = ldo_three_reg[ON_BIT];
  assign rail6_op_mode = buck_six_reg[MODE_BIT];
  // Trim fields other than the kept value void voltage codes
  assign rail6_vid_valid     = buck_six_reg[BUCK_TRIM_LSB +: 2] == BUCK_TRIM_OK;
  assign ldo_two_vid_valid   = ldo_two_reg[LDO_TRIM_LSB +: 3] == LDO_TRIM_OK;
  assign ldo_three_vid_valid = ldo_three_reg[LDO_TRIM_LSB +: 3] == LDO_TRIM_OK;
  assign rail1_discharge_sel = disch_reg[1:0];
  assign rail2_discharge_sel = disch_reg[3:2];
  assign rail3_discharge_sel = disch_reg[5:4];
  assign rail4_discharge_sel = disch_reg[7:6];

  wire arm_six   = buck_six_reg[ARM_LSB +: 2] != ARM_OFF;
  wire arm_two   = ldo_two_reg[ARM_LSB +: 2] != ARM_OFF;
  wire arm_three = ldo_three_reg[ARM_LSB +: 2] != ARM_OFF;

  rail_sleep_track u_six (
    .sys_clk     (sys_clk),
    .sys_rst     (sys_rst),
    .clk_en      (clk_en),
    .sleep_armed (arm_six),
    .sleep_level (sleep_level),
    .normal_code (rail6_voltage_code),
    .sleep_code  (rail6_sleep_voltage_code),
    .active_code (rail6_active_code)
  );
  rail_sleep_track u_two (
    .sys_clk     (sys_clk),
    .sys_rst     (sys_rst),
    .clk_en      (clk_en),
    .sleep_armed (arm_two),
    .sleep_level (sleep_level),
    .normal_code (ldo_two_voltage_code),
    .sleep_code  (ldo_two_sleep_voltage_code),
    .active_code (ldo_two_active_code)
  );
  rail_sleep_track u_three (
    .sys_clk     (sys_clk),
    .sys_rst     (sys_rst),
    .clk_en      (clk_en),
    .sleep_armed (arm_three),
    .sleep_level (sleep_level),
    .normal_code (ldo_three_voltage_code),
    .sleep_code  (ldo_three_sleep_voltage_code),
    .active_code (ldo_three_active_code)
  );
endmodule

// File: sim/rail_control_regs_properties.sv
// Assertions and covers for the rail control register bank
`timescale 1ns/1ps
module rail_control_regs_properties (
  input wire logic       sys_clk,
  input wire logic       sys_rst,
  input wire logic       clk_en,
  input wire logic       wr_en,
  input wire logic [7:0] addr,
  input wire logic [7:0] wr_data,
  input wire logic [7:0] rd_data,
  input wire logic [3:0] rail_enable_evt,
  input wire logic       rail6_on,
  input wire logic       rail6_op_mode,
  input wire logic       ldo_two_on,
  input wire logic       ldo_three_on,
  input wire logic [1:0] rail1_discharge_sel
);
  wire w27 = clk_en && wr_en && addr == 8'h27;
  wire w28 = clk_en && wr_en && addr == 8'h28;
  wire w29 = clk_en && wr_en && addr == 8'h29;
  // Enable events win over a write, so only clean writes are compared
  wire w40 = clk_en && wr_en && addr == 8'h40 && rail_enable_evt == 4'h0;
  default clocking @(posedge sys_clk); endclocking
  default disable iff (sys_rst);
  chk_rsv_read_zero: assert property (addr[7:4] == 4'h2 |-> rd_data[7:6] == 2'h0)
    else $error("reserved bits not zero");
  chk_six_on: assert property (w27 |=> rail6_on == $past(wr_data[0]))
    else $error("rail six on bit wrong");
  chk_six_mode: assert property (w27 |=> rail6_op_mode == $past(wr_data[1]))
    else $error("rail six mode wrong");
  chk_two_on: assert property (w28 |=> ldo_two_on == $past(wr_data[0]))
    else $error("ldo two on bit wrong");
  chk_three_on: assert property (w29 |=> ldo_three_on == $past(wr_data[0]))
    else $error("ldo three on bit wrong");
  chk_disch_clear: assert property (clk_en && rail_enable_evt[0] |=> rail1_discharge_sel == 2'h0)
    else $error("discharge field not cleared");
  chk_disch_store: assert property (w40 ##1 addr == 8'h40 |-> rd_data == $past(wr_data))
    else $error("discharge write lost");
  chk_hold_frozen: assert property (!clk_en |=> $stable(rail6_on) && $stable(ldo_two_on))
    else $error("state moved while frozen");
  cover property (w27 ##1 !rail6_on);
  cover property (rail_enable_evt != 4'h0);
  cover property (!clk_en && wr_en);
endmodule
bind rail_control_regs rail_control_regs_properties chk (.*);

// File: sim/rail_control_regs_tb.sv
// Self-checking bench for the rail control register bank
`timescale 1ns/1ps
module rail_control_regs_tb;
  import rail_regs_pkg::*;
  logic        sys_clk = 0, sys_rst = 1, clk_en = 1, wr_en = 0;
  logic        sleep_pin_one = 0, sleep_pin_two = 0, sleep_pin_sel = 0;
  logic [7:0]  addr = 0, wr_data = 0, rd_data;
  logic [3:0]  rail_enable_evt = 0;
  logic [6:0]  nc = 7'h05, sc = 7'h09, rail6_active_code, ldo_two_active_code, ldo_three_active_code;
  logic        rail6_on, rail6_op_mode, rail6_vid_valid, ldo_two_on, ldo_two_vid_valid;
  logic        ldo_three_on, ldo_three_vid_valid;
  logic [1:0]  rail1_discharge_sel, rail2_discharge_sel, rail3_discharge_sel, rail4_discharge_sel;
  int          failures = 0, total_checks = 0, cyc = 0;
  logic [23:0] rows [6] = '{24'h27ff3f, 24'h270000, 24'h28ff3f, 24'h29c101, 24'h40a5a5, 24'h33ff00};
  always #2.5 sys_clk = ~sys_clk;
  rail_control_regs dut (.*, .rail6_voltage_code(nc), .rail6_sleep_voltage_code(sc),
    .ldo_two_voltage_code(nc), .ldo_two_sleep_voltage_code(sc),
    .ldo_three_voltage_code(nc), .ldo_three_sleep_voltage_code(sc));
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    total_checks++;
    if (seen !== exp) begin
      failures++;
      $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    addr <= a;
    wr_data <= d;
    wr_en <= 1'b1;
    @(posedge sys_clk);
    wr_en <= 1'b0;
  endtask
  // Read data is combinational, so one ns after the edge is settled
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    @(posedge sys_clk);
    addr <= a;
    #1 chk(rd_data, exp);
  endtask
  task automatic end_sim;
    $display("checks %0d failures %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  always @(posedge sys_clk) begin
    cyc <= cyc + 1;
    if (cyc == 2000) begin
      failures++;
      end_sim();
    end
  end
  initial begin
    repeat (20) @(posedge sys_clk);
    sys_rst <= 1'b0;
    rd(8'h27, BUCK_SIX_RST);
    rd(8'h28, LDO_TWO_RST);
    rd(8'h29, LDO_THREE_RST);
    rd(8'h40, DISCH_ONE_RST);
    $display("reset test done");
    foreach (rows[i]) begin
      wr(rows[i][23:16], rows[i][15:8]);
      rd(rows[i][23:16], rows[i][7:0]);
    end
    chk(rail6_on, 1'b0);
    chk(ldo_two_vid_valid, 1'b0);
    chk(ldo_three_vid_valid, 1'b0);
    $display("table test done");
    wr(8'h28, 8'h0d);
    wr(8'h29, 8'h3d);
    wr(8'h27, 8'h1c);
    sleep_pin_one <= 1'b1;
    repeat (2) @(posedge sys_clk);
    #1 chk(rail6_active_code, sc);
    chk(ldo_three_active_code, sc);
    chk(ldo_two_active_code, nc);
    chk(ldo_three_vid_valid, 1'b1);
    chk(rail6_vid_valid, 1'b1);
    chk(rail6_op_mode, 1'b0);
    @(posedge sys_clk);
    sleep_pin_sel <= 1'b1;
    repeat (2) @(posedge sys_clk);
    #1 chk(ldo_three_active_code, nc);
    @(posedge sys_clk);
    rail_enable_evt <= 4'h3;
    @(posedge sys_clk);
    rail_enable_evt <= 4'h0;
    rd(8'h40, 8'ha0);
    @(posedge sys_clk);
    clk_en <= 1'b0;
    wr(8'h27, 8'h03);
    clk_en <= 1'b1;
    rd(8'h27, 8'h1c);
    @(posedge sys_clk);
    sys_rst <= 1'b1;
    @(posedge sys_clk);
    sys_rst <= 1'b0;
    rd(8'h40, DISCH_ONE_RST);
    $display("sleep, discharge and freeze tests done");
    end_sim();
  end
endmodule
